/* File: hdl/fdc_ctrl.sv */
// Feedback divider word register with fast-lock timer and charge pump scaling.
// Assumes words arrive already deserialised as one strobe with 24 data bits,
// and a one-cycle pulse per phase comparator reference cycle.
`timescale 1ns/1ps
`include "fdc_regs.svh"

// Function
// - Words with address code 00 go to the feedback divider register.
// - Nine bits of the word become the integer division part.
// - Twelve bits become the interpolator numerator of the fractional part.
// - Fast-lock bit one starts fast-lock mode if the loaded timer value is nonzero; a zero value leaves the mode as it was.
// - While the timer runs, charge pump setting is sixteen times minimum.
// - When the timer expires, charge pump returns to one times minimum.
// - Reference word with load bit set loads the timer, denominator unchanged.
// - The timer counts phase comparator reference cycles.
// - A new denominator applies only at the next feedback divider write.
// - A feedback divider write clears the digital lock detect output.
module fdc_ctrl
    import fdc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_word_stb,
    input wire logic [`FDC_WORD_W-1:0] i_word,
    input wire logic i_ref_tick,
    output logic [8:0] o_int,
    output logic [11:0] o_num,
    output logic [11:0] o_den,
    output logic o_ratio_apply,
    output logic [4:0] o_cp_mult,
    output logic o_fast_active,
    output logic o_lock_clear
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic addr_is(input logic [`FDC_WORD_W-1:0] w, input logic [1:0] code);
        addr_is = (w[`FDC_ADDR_MSB:`FDC_ADDR_LSB] == code);
    endfunction

    fdc_regs_t s_r;
    fdc_regs_t s_nxt;
    logic fb_wr;
    logic ref_wr;

    assign fb_wr = i_word_stb && addr_is(i_word, `FDC_ADDR_FB);
    assign ref_wr = i_word_stb && addr_is(i_word, `FDC_ADDR_REF);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.apply_r = 1'b0;
        s_nxt.lock_clr_r = 1'b0;
        if (ref_wr) begin
            if (i_word[`FDC_LOADCTL_BIT]) begin
                // With the load bit set the field is a timer value, never a denominator.
                s_nxt.tmr_load_r = i_word[`FDC_DEN_MSB:`FDC_DEN_LSB];
            end else begin
                // Held pending: the counters must not see it mid-channel.
                s_nxt.den_pend_r = i_word[`FDC_DEN_MSB:`FDC_DEN_LSB];
            end
        end
        case (s_r.st)
            FDC_IDLE: begin
                s_nxt.cp_mult_r = `FDC_CP_MULT_LO;
            end
            FDC_FAST: begin
                if (i_ref_tick) begin
                    // The last tick ends the wide-bandwidth run and clears the count.
                    if (s_r.tmr_r <= 12'h001) begin
                        s_nxt.st = FDC_IDLE;
                        s_nxt.tmr_r = 12'h000;
                        s_nxt.cp_mult_r = `FDC_CP_MULT_LO;
                    end else begin
                        s_nxt.tmr_r = s_r.tmr_r - 12'h001;
                    end
                end
            end
            default: begin
                s_nxt.st = FDC_IDLE;
                s_nxt.cp_mult_r = `FDC_CP_MULT_LO;
            end
        endcase
        // The divider write comes last so it wins over a tick in the same cycle, except a fast-lock write with a zero timer value.
        if (fb_wr) begin
            s_nxt.int_r = i_word[`FDC_INT_MSB:`FDC_INT_LSB];
            s_nxt.num_r = i_word[`FDC_PARTIAL_STEP_NUMERATOR_MSB:`FDC_PARTIAL_STEP_NUMERATOR_LSB];
            s_nxt.den_r = s_r.den_pend_r;
            s_nxt.apply_r = 1'b1;
            s_nxt.lock_clr_r = 1'b1;
            // A zero timer value gives no wide-bandwidth period at all.
            if (i_word[`FDC_FAST_BIT] && s_r.tmr_load_r != 12'h000) begin
                s_nxt.st = FDC_FAST;
                s_nxt.tmr_r = s_r.tmr_load_r;
                s_nxt.cp_mult_r = `FDC_CP_MULT_HI;
            end else if (!i_word[`FDC_FAST_BIT]) begin
                s_nxt.st = FDC_IDLE;
                s_nxt.tmr_r = 12'h000;
                s_nxt.cp_mult_r = `FDC_CP_MULT_LO;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // A low enable holds every field, pulses included, so a pulse lasts one enabled cycle.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_r <= '{st: FDC_IDLE,
                     int_r: '0,
                     num_r: '0,
                     den_pend_r: `FDC_DEN_RST,
                     den_r: `FDC_DEN_RST,
                     tmr_load_r: '0,
                     tmr_r: '0,
                     cp_mult_r: `FDC_CP_MULT_LO,
                     apply_r: 1'b0,
                     lock_clr_r: 1'b0};
        end else if (i_ce) begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // All outputs are state fields; fast-lock is the set bit of its one-hot state code.
    assign o_int = s_r.int_r;
    assign o_num = s_r.num_r;
    assign o_den = s_r.den_r;
    assign o_ratio_apply = s_r.apply_r;
    assign o_cp_mult = s_r.cp_mult_r;
    assign o_fast_active = s_r.st[`FDC_ST_FAST_BIT];
    assign o_lock_clear = s_r.lock_clr_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // A low enable freezes the pulses too, so pulse checks look at enabled cycles only.
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    a_fb_addr_decode: assert property (
        i_ce && i_word_stb && !addr_is(i_word, `FDC_ADDR_FB) |=> !o_ratio_apply)
        else $error("ratio applied for a word of another address");
    a_ref_keeps_ratio: assert property (
        i_ce && ref_wr |=> $stable(o_int) && $stable(o_num))
        else $error("reference word changed the ratio");
    a_int_capture: assert property (
        i_ce && fb_wr |=> o_int == $past(i_word[`FDC_INT_MSB:`FDC_INT_LSB]))
        else $error("integer part not captured");
    a_num_capture: assert property (
        i_ce && fb_wr |=> o_num == $past(i_word[`FDC_PARTIAL_STEP_NUMERATOR_MSB:`FDC_PARTIAL_STEP_NUMERATOR_LSB]))
        else $error("numerator not captured");
    a_fast_start: assert property (
        i_ce && fb_wr && i_word[`FDC_FAST_BIT] && s_r.tmr_load_r != 12'h000
        |=> o_fast_active && o_cp_mult == `FDC_CP_MULT_HI)
        else $error("fast-lock did not start");
    a_fast_cancel: assert property (
        i_ce && fb_wr && !i_word[`FDC_FAST_BIT] |=> !o_fast_active)
        else $error("fast-lock not cancelled by a cleared fast-lock bit");
    a_fast_refuse: assert property (
        i_ce && fb_wr && s_r.tmr_load_r == 12'h000 && !o_fast_active
        |=> !o_fast_active)
        else $error("fast-lock started with no timer value");
    a_fast_mult: assert property (
        o_fast_active |-> o_cp_mult == `FDC_CP_MULT_HI)
        else $error("charge pump not at sixteen times during fast-lock");
    a_fast_end: assert property (
        i_ce && o_fast_active && i_ref_tick && s_r.tmr_r == 12'h001 && !fb_wr
        |=> !o_fast_active && o_cp_mult == `FDC_CP_MULT_LO)
        else $error("charge pump did not return to one times");
    a_idle_mult: assert property (
        !o_fast_active |-> o_cp_mult == `FDC_CP_MULT_LO)
        else $error("charge pump above one times outside fast-lock");
    a_timer_load: assert property (
        i_ce && ref_wr && i_word[`FDC_LOADCTL_BIT] |=> $stable(s_r.den_pend_r))
        else $error("timer load disturbed the denominator");
    a_timer_route: assert property (
        i_ce && ref_wr && i_word[`FDC_LOADCTL_BIT]
        |=> s_r.tmr_load_r == $past(i_word[`FDC_DEN_MSB:`FDC_DEN_LSB]))
        else $error("timer value not taken from the reference word");
    a_tick_count: assert property (
        i_ce && o_fast_active && !i_ref_tick && !fb_wr |=> $stable(s_r.tmr_r))
        else $error("timer moved without a reference tick");
    a_tick_step: assert property (
        i_ce && o_fast_active && i_ref_tick && s_r.tmr_r > 12'h001 && !fb_wr
        |=> s_r.tmr_r == $past(s_r.tmr_r) - 12'h001)
        else $error("timer did not step down on a reference tick");
    a_den_defer: assert property (
        i_ce && !fb_wr |=> $stable(o_den))
        else $error("denominator changed without a divider write");
    a_den_route: assert property (
        i_ce && ref_wr && !i_word[`FDC_LOADCTL_BIT]
        |=> s_r.den_pend_r == $past(i_word[`FDC_DEN_MSB:`FDC_DEN_LSB]))
        else $error("denominator not held from the reference word");
    a_den_apply: assert property (
        i_ce && fb_wr |=> o_den == $past(s_r.den_pend_r))
        else $error("held denominator not applied");
    a_lock_clear: assert property (
        i_ce && fb_wr |=> o_lock_clear)
        else $error("lock clear not raised");
    a_clear_pulse: assert property (
        i_ce && o_lock_clear && !fb_wr |=> !o_lock_clear)
        else $error("lock clear held past one cycle");
    a_apply_pulse: assert property (
        i_ce && fb_wr |=> o_ratio_apply)
        else $error("ratio not applied after a divider write");

    c_fast_run: cover property (o_fast_active ##1 !o_fast_active);
    c_den_apply: cover property (ref_wr ##[1:20] fb_wr);
    c_timer_set: cover property (ref_wr && i_word[`FDC_LOADCTL_BIT]);
    c_fast_cancel: cover property (o_fast_active && fb_wr && !i_word[`FDC_FAST_BIT]);
    c_frozen_tick: cover property (o_fast_active && i_ref_tick && !i_ce);

endmodule

/* File: hdl/fdc_pkg.sv */
// Types for the feedback divider and fast-lock control block.
// Assumes fdc_regs.svh is visible on the include path.
package fdc_pkg;
    typedef enum logic [1:0] {
        FDC_IDLE = 2'b01,
        FDC_FAST = 2'b10
    } fdc_state_t;

    typedef struct packed {
        fdc_state_t st;
        logic [8:0] int_r;
        logic [11:0] num_r;
        logic [11:0] den_pend_r;
        logic [11:0] den_r;
        logic [11:0] tmr_load_r;
        logic [11:0] tmr_r;
        logic [4:0] cp_mult_r;
        logic apply_r;
        logic lock_clr_r;
    } fdc_regs_t;
endpackage

/* File: hdl/fdc_regs.svh */
// Register word layout and control constants for the feedback divider block.
// Assumes 24-bit serial words, address code in the two low bits.
`ifndef FDC_REGS_SVH
`define FDC_REGS_SVH

`define FDC_WORD_W 24
`define FDC_ADDR_LSB 0
`define FDC_ADDR_MSB 1
`define FDC_ADDR_FB 2'h0
`define FDC_ADDR_REF 2'h1
`define FDC_PARTIAL_STEP_NUMERATOR_LSB 2
`define FDC_PARTIAL_STEP_NUMERATOR_MSB 13
`define FDC_INT_LSB 14
`define FDC_INT_MSB 22
`define FDC_FAST_BIT 23
`define FDC_LOADCTL_BIT 23
`define FDC_DEN_LSB 2
`define FDC_DEN_MSB 13
`define FDC_DEN_RST 12'h001
`define FDC_CP_MULT_HI 5'h10
`define FDC_CP_MULT_LO 5'h01
`define FDC_ST_FAST_BIT 1

`endif

/* File: verif/fdc_host.sv */
// Host model that writes whole serial words as one-cycle strobes.
// Assumes the bench calls send only after reset has been released.
`timescale 1ns/1ps
`include "fdc_regs.svh"
module fdc_host (
    input wire logic i_mclk,
    output logic o_word_stb,
    output logic [`FDC_WORD_W-1:0] o_word
);
    initial begin
        o_word_stb = 1'b0;
        o_word = '0;
    end
    // Between words the data lines carry the inverse, so stale bits never look valid.
    task automatic send(input logic [`FDC_WORD_W-1:0] w);
        @(posedge i_mclk);
        #1;
        o_word_stb = 1'b1;
        o_word = w;
        @(posedge i_mclk);
        #1;
        o_word_stb = 1'b0;
        o_word = ~w;
    endtask
endmodule

/* File: verif/feedback_divider_fastlock_ctrl_test.sv */
// Self-checking bench for the feedback divider and fast-lock block.
// Assumes the host model supplies words and the bench supplies reference ticks.
`timescale 1ns/1ps
`include "fdc_regs.svh"
module feedback_divider_fastlock_ctrl_test;
    import fdc_pkg::*;
    typedef struct packed {
        logic [23:0] w;
        logic [8:0] i;
        logic [11:0] n;
        logic [11:0] d;
        logic a;
    } fdc_row_t;
    logic i_mclk, i_rst_n, i_ce, i_word_stb, i_ref_tick, o_ratio_apply, o_fast_active;
    logic o_lock_clear;
    logic [23:0] i_word;
    logic [8:0] o_int;
    logic [11:0] o_num, o_den;
    logic [4:0] o_cp_mult;
    fdc_row_t rows [6];
    int n_mismatch = 0;
    int num_checks = 0;
    fdc_host host (.i_mclk(i_mclk), .o_word_stb(i_word_stb), .o_word(i_word));
    fdc_ctrl dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_word_stb(i_word_stb),
        .i_word(i_word), .i_ref_tick(i_ref_tick), .o_int(o_int), .o_num(o_num), .o_den(o_den),
        .o_ratio_apply(o_ratio_apply), .o_cp_mult(o_cp_mult), .o_fast_active(o_fast_active),
        .o_lock_clear(o_lock_clear));
    function automatic logic [23:0] fbw(logic f, logic [8:0] i, logic [11:0] n);
        return {f, i, n, 2'h0};
    endfunction
    function automatic logic [23:0] refw(logic l, logic [11:0] v);
        return {l, 9'h000, v, 2'h1};
    endfunction
    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic tick(input logic ce);
        @(posedge i_mclk);
        #1;
        i_ce = ce;
        i_ref_tick = 1'b1;
        @(posedge i_mclk);
        #1;
        i_ce = 1'b1;
        i_ref_tick = 1'b0;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end
    initial begin
        #100000;
        n_mismatch++;
        final_report();
    end
    initial begin
        i_rst_n = 1'b0;
        i_ce = 1'b1;
        i_ref_tick = 1'b0;
        rows[0] = '{fbw(0, 9'h1ff, 12'h000), 9'h1ff, 12'h000, 12'h001, 1'b1};
        rows[1] = '{refw(0, 12'hfff), 9'h1ff, 12'h000, 12'h001, 1'b0};
        rows[2] = '{fbw(0, 9'h005, 12'hffe), 9'h005, 12'hffe, 12'hfff, 1'b1};
        rows[3] = '{24'h7ffffe, 9'h005, 12'hffe, 12'hfff, 1'b0};
        rows[4] = '{24'h800003, 9'h005, 12'hffe, 12'hfff, 1'b0};
        rows[5] = '{refw(1, 12'h003), 9'h005, 12'hffe, 12'hfff, 1'b0};
        repeat (5) @(posedge i_mclk);
        #1;
        chk(o_den === `FDC_DEN_RST && o_cp_mult === `FDC_CP_MULT_LO, "reset values");
        i_rst_n = 1'b1;
        foreach (rows[k]) begin
            host.send(rows[k].w);
            chk(o_int === rows[k].i && o_num === rows[k].n, "int or num");
            chk(o_den === rows[k].d, "denominator");
            chk(o_ratio_apply === rows[k].a && o_lock_clear === rows[k].a, "pulses");
        end
        $display("row tests done");
        host.send(fbw(1, 9'h005, 12'h001));
        chk(o_cp_mult === `FDC_CP_MULT_HI && o_fast_active === 1'b1, "fast start");
        tick(1'b0);
        tick(1'b1);
        tick(1'b1);
        chk(o_cp_mult === `FDC_CP_MULT_HI && o_fast_active === 1'b1, "fast held");
        tick(1'b1);
        chk(o_cp_mult === `FDC_CP_MULT_LO && o_fast_active === 1'b0, "fast end");
        host.send(fbw(1, 9'h005, 12'h001));
        chk(o_fast_active === 1'b1 && o_cp_mult === `FDC_CP_MULT_HI, "restart");
        host.send(fbw(0, 9'h005, 12'h001));
        chk(o_cp_mult === `FDC_CP_MULT_LO && o_fast_active === 1'b0, "fast cancel");
        $display("fast-lock tests done");
        host.send(fbw(1, 9'h005, 12'h001));
        i_rst_n = 1'b0;
        repeat (2) @(posedge i_mclk);
        #1;
        chk(o_fast_active === 1'b0 && o_cp_mult === `FDC_CP_MULT_LO, "mid-run reset");
        chk(o_int === 9'h000 && o_den === `FDC_DEN_RST && o_lock_clear === 1'b0, "reset state");
        i_rst_n = 1'b1;
        host.send(fbw(1, 9'h007, 12'h000));
        chk(o_fast_active === 1'b0 && o_cp_mult === `FDC_CP_MULT_LO, "no timer");
        chk(o_int === 9'h007 && o_den === `FDC_DEN_RST, "ratio after reset");
        chk(o_ratio_apply === 1'b1, "apply after reset");
        $display("reset tests done");
        final_report();
    end
endmodule
